/* File: inc/driver_status_flags_pkg.sv */
// Constants for the driver status flag register block
package driver_status_flags_pkg;
    // ==========================================================
    // Register indices and byte addresses
    localparam logic [11:0] FLAGS_IDX       = 12'h06F;
    localparam logic [11:0] IRQ_STATUS_IDX  = 12'h070;
    localparam logic [11:0] IRQ_MASK_IDX    = 12'h071;
    localparam logic [11:0] DRV_CTRL_IDX    = 12'h072;
    localparam logic [11:0] FLAGS_ADDR      = {FLAGS_IDX[9:0], 2'b00};
    localparam logic [11:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX[9:0], 2'b00};
    localparam logic [11:0] IRQ_MASK_ADDR   = {IRQ_MASK_IDX[9:0], 2'b00};
    localparam logic [11:0] DRV_CTRL_ADDR   = {DRV_CTRL_IDX[9:0], 2'b00};
    // ==========================================================
    // Status word field positions
    localparam int STST_BIT      = 31;
    localparam int OLB_BIT       = 30;
    localparam int OLA_BIT       = 29;
    localparam int GSB_BIT       = 28;
    localparam int GSA_BIT       = 27;
    localparam int OTPW_BIT      = 26;
    localparam int OVT_BIT       = 25;
    localparam int STALL_BIT     = 24;
    localparam int CS_MSB        = 20;
    localparam int CS_LSB        = 16;
    localparam int FS_BIT        = 15;
    localparam int QUIET_BIT     = 14;
    localparam int VSB_BIT       = 13;
    localparam int VSA_BIT       = 12;
    localparam int LOAD_MSB      = 9;
    localparam int LOAD_W        = 10;
    localparam int CS_W          = 5;
    // ==========================================================
    // Interrupt status and mask layout
    localparam int IRQ_W         = 7;
    localparam int IRQ_STANDSTILL = 0;
    localparam int IRQ_STALL     = 1;
    localparam int IRQ_GND_SHORT = 2;
    localparam int IRQ_VS_SHORT  = 3;
    localparam int IRQ_OTPW      = 4;
    localparam int IRQ_OVT       = 5;
    localparam int IRQ_OPEN_LOAD = 6;
    // ==========================================================
    // Control register and reset values
    localparam int              OFF_TIME_W      = 4;
    localparam logic [3:0]      OFF_TIME_RESET  = 4'h0;
    localparam logic [3:0]      OFF_TIME_ZERO   = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 7'h00;
    localparam logic [31:0]     STATUS_RESET    = 32'h0000_0000;
    localparam logic [31:0]     STST_CYCLES     = 32'h0010_0000;
    localparam logic [7:0]      VS_THRESH       = 8'hC0;
    localparam int              SYNC_W          = 8;
    localparam logic [7:0]      SYNC_RESET      = 8'hC0;
endpackage

/* File: inc/stst_if.sv */
// Carrier between the status block and its standstill timer
`timescale 1ns/10ps
interface stst_if;
    logic step_seen;
    logic standstill;
    modport timer (input step_seen, output standstill);
    modport user  (output step_seen, input standstill);
endinterface

/* File: hdl/standstill_timer.sv */
// Standstill timeout counter restarted by step pulses
`timescale 1ns/10ps
module standstill_timer #(
    parameter logic [31:0] CYCLES = driver_status_flags_pkg::STST_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    stst_if.timer     t
);
    // ==========================================================
    // Timeout counter
    logic [31:0] count_q;
    logic        stst_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h0000_0000;
            stst_q  <= 1'b0;
        end else if (t.step_seen) begin
            count_q <= 32'h0000_0000;
            stst_q  <= 1'b0;
        end else if (count_q >= CYCLES - 32'h0000_0001) begin
            stst_q  <= 1'b1;
        end else begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    assign t.standstill = stst_q;

    // ==========================================================
    // Checks
    a_stst_restart: assert property (@(posedge pclk) disable iff (!presetn)
        t.step_seen |=> !stst_q)
        else $error("standstill not cleared by step");
    a_stst_timeout: assert property (@(posedge pclk) disable iff (!presetn)
        (count_q == CYCLES - 32'h0000_0001) && !t.step_seen |=> stst_q)
        else $error("standstill late after timeout");
endmodule // standstill_timer

/* File: hdl/driver_status_regs.sv */
// Driver status flag register with fault latches, interrupts and APB access
//
// Operation
// - The status word is one read-only 32-bit register at index 0x6F.
// - Bit 31 sets after 2^20 clocks without a step pulse and restarts at each step.
// - Bits 30 and 29 report open load on phase B and A and never disable the driver.
// - A ground short sets bit 28 or 27, disables the driver and latches until off time is zero or enable pin is off.
// - A supply short sets bit 13 or 12, disables the driver and latches the same way.
// - The supply short decision includes the sense resistor drop with the bridge drop.
// - Bit 26 shows the common overtemperature pre-warning while it is exceeded.
// - Bit 25 shows overtemperature and keeps the drivers off until the pre-warning has cleared too.
// - Bit 24 sets when the load value is zero or a load-speed mode stall is seen.
// - Bits 20 to 16 carry the actual current scale.
// - Bit 15 shows that the driver runs in fullstep.
// - Bit 14 shows that the quiet voltage-mode chopper is active.
// - Stall detection compares the load value in the low bits with zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module driver_status_regs #(
    parameter logic [31:0] STST_CYCLES = driver_status_flags_pkg::STST_CYCLES,
    parameter logic [7:0]  VS_THRESH   = driver_status_flags_pkg::VS_THRESH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        step_pin,
    input  wire logic        driver_enable_pin_n,
    input  wire logic        gnd_short_det_a,
    input  wire logic        gnd_short_det_b,
    input  wire logic        open_load_det_a,
    input  wire logic        open_load_det_b,
    input  wire logic        otpw_det,
    input  wire logic        overtemp_det,
    input  wire logic [7:0]  bridge_drop_a,
    input  wire logic [7:0]  bridge_drop_b,
    input  wire logic [7:0]  sense_drop_a,
    input  wire logic [7:0]  sense_drop_b,
    input  wire logic [9:0]  load_measurement_value,
    input  wire logic [4:0]  current_scale,
    input  wire logic        fullstep_active,
    input  wire logic        quiet_chopper_active,
    input  wire logic        load_speed_mode,
    input  wire logic        load_speed_stall,
    output logic             driver_disable,
    output logic      [3:0]  chopper_off_time,
    output logic             irq
);
    // ==========================================================
    // Pin synchronisers
    logic [driver_status_flags_pkg::SYNC_W-1:0] sync1_q;
    logic [driver_status_flags_pkg::SYNC_W-1:0] sync2_q;
    logic                              step_prev_q;
    logic                              step_s;
    logic                              en_pin_s;
    logic                              gsa_s;
    logic                              gsb_s;
    logic                              ola_s;
    logic                              olb_s;
    logic                              otpw_s;
    logic                              ovt_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q     <= driver_status_flags_pkg::SYNC_RESET;
            sync2_q     <= driver_status_flags_pkg::SYNC_RESET;
            step_prev_q <= 1'b1;
        end else begin
            sync1_q     <= {step_pin, driver_enable_pin_n, gnd_short_det_a, gnd_short_det_b,
                            open_load_det_a, open_load_det_b, otpw_det, overtemp_det};
            sync2_q     <= sync1_q;
            step_prev_q <= sync2_q[7];
        end
    end

    assign step_s = sync2_q[7];
    assign en_pin_s = sync2_q[6];
    assign gsa_s  = sync2_q[5];
    assign gsb_s  = sync2_q[4];
    assign ola_s  = sync2_q[3];
    assign olb_s  = sync2_q[2];
    assign otpw_s = sync2_q[1];
    assign ovt_s  = sync2_q[0];

    // ==========================================================
    // Standstill timer
    stst_if st ();

    assign st.step_seen = step_s & ~step_prev_q;

    standstill_timer #(
        .CYCLES (STST_CYCLES)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (st.timer)
    );

    // ==========================================================
    // APB decode
    logic        access;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    assign access = psel & penable & pready_q;
    assign wr_en  = access & pwrite;
    assign rd_en  = access & ~pwrite;

    // ==========================================================
    // Control register
    logic [3:0] off_time_q;
    logic       flag_clear;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_time_q <= driver_status_flags_pkg::OFF_TIME_RESET;
        end else if (wr_en && paddr == driver_status_flags_pkg::DRV_CTRL_ADDR) begin
            off_time_q <= pwdata[driver_status_flags_pkg::OFF_TIME_W-1:0];
        end
    end

    assign flag_clear = (off_time_q == driver_status_flags_pkg::OFF_TIME_ZERO) | en_pin_s;

    // ==========================================================
    // Short detection latches
    logic [8:0] vs_sum_a;
    logic [8:0] vs_sum_b;
    logic       vs_det_a;
    logic       vs_det_b;
    logic       gsa_q;
    logic       gsb_q;
    logic       vsa_q;
    logic       vsb_q;

    assign vs_sum_a = {1'b0, bridge_drop_a} + {1'b0, sense_drop_a};
    assign vs_sum_b = {1'b0, bridge_drop_b} + {1'b0, sense_drop_b};
    assign vs_det_a = vs_sum_a > {1'b0, VS_THRESH};
    assign vs_det_b = vs_sum_b > {1'b0, VS_THRESH};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gsa_q <= 1'b0;
            gsb_q <= 1'b0;
        end else begin
            gsa_q <= gsa_s | (gsa_q & ~flag_clear);
            gsb_q <= gsb_s | (gsb_q & ~flag_clear);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vsa_q <= 1'b0;
            vsb_q <= 1'b0;
        end else begin
            vsa_q <= vs_det_a | (vsa_q & ~flag_clear);
            vsb_q <= vs_det_b | (vsb_q & ~flag_clear);
        end
    end

    // ==========================================================
    // Overtemperature latch
    logic ovt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovt_q <= 1'b0;
        end else begin
            ovt_q <= ovt_s | (ovt_q & otpw_s);
        end
    end

    // ==========================================================
    // Driver disable
    logic drv_off_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_off_q <= 1'b1;
        end else begin
            drv_off_q <= gsa_q | gsb_q | vsa_q | vsb_q | ovt_q | flag_clear;
        end
    end

    // ==========================================================
    // Status word
    logic        stall;
    logic [31:0] status_d;
    logic [31:0] status_q;

    assign stall = (load_measurement_value == 10'h000) | (load_speed_mode & load_speed_stall);

    always_comb begin
        status_d = driver_status_flags_pkg::STATUS_RESET;
        status_d[driver_status_flags_pkg::STST_BIT]  = st.standstill;
        status_d[driver_status_flags_pkg::OLB_BIT]   = olb_s;
        status_d[driver_status_flags_pkg::OLA_BIT]   = ola_s;
        status_d[driver_status_flags_pkg::GSB_BIT]   = gsb_q;
        status_d[driver_status_flags_pkg::GSA_BIT]   = gsa_q;
        status_d[driver_status_flags_pkg::OTPW_BIT]  = otpw_s;
        status_d[driver_status_flags_pkg::OVT_BIT]   = ovt_q;
        status_d[driver_status_flags_pkg::STALL_BIT] = stall;
        status_d[driver_status_flags_pkg::CS_MSB:driver_status_flags_pkg::CS_LSB] = current_scale;
        status_d[driver_status_flags_pkg::FS_BIT]    = fullstep_active;
        status_d[driver_status_flags_pkg::QUIET_BIT] = quiet_chopper_active;
        status_d[driver_status_flags_pkg::VSB_BIT]   = vsb_q;
        status_d[driver_status_flags_pkg::VSA_BIT]   = vsa_q;
        status_d[driver_status_flags_pkg::LOAD_MSB:0] = load_measurement_value;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= driver_status_flags_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ==========================================================
    // Interrupt status and mask
    logic [driver_status_flags_pkg::IRQ_W-1:0] irq_ev;
    logic [driver_status_flags_pkg::IRQ_W-1:0] irq_clr;
    logic [driver_status_flags_pkg::IRQ_W-1:0] irq_stat_q;
    logic [driver_status_flags_pkg::IRQ_W-1:0] irq_mask_q;
    logic [31:0]                      rise;
    logic                             irq_q;

    assign rise = status_d & ~status_q;

    always_comb begin
        irq_ev = '0;
        irq_ev[driver_status_flags_pkg::IRQ_STANDSTILL] = rise[driver_status_flags_pkg::STST_BIT];
        irq_ev[driver_status_flags_pkg::IRQ_STALL]      = rise[driver_status_flags_pkg::STALL_BIT];
        irq_ev[driver_status_flags_pkg::IRQ_GND_SHORT]  = rise[driver_status_flags_pkg::GSA_BIT] | rise[driver_status_flags_pkg::GSB_BIT];
        irq_ev[driver_status_flags_pkg::IRQ_VS_SHORT]   = rise[driver_status_flags_pkg::VSA_BIT] | rise[driver_status_flags_pkg::VSB_BIT];
        irq_ev[driver_status_flags_pkg::IRQ_OTPW]       = rise[driver_status_flags_pkg::OTPW_BIT];
        irq_ev[driver_status_flags_pkg::IRQ_OVT]        = rise[driver_status_flags_pkg::OVT_BIT];
        irq_ev[driver_status_flags_pkg::IRQ_OPEN_LOAD]  = rise[driver_status_flags_pkg::OLA_BIT] | rise[driver_status_flags_pkg::OLB_BIT];
    end

    assign irq_clr = (wr_en && paddr == driver_status_flags_pkg::IRQ_STATUS_ADDR) ?
                     pwdata[driver_status_flags_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= driver_status_flags_pkg::IRQ_MASK_RESET;
        end else if (wr_en && paddr == driver_status_flags_pkg::IRQ_MASK_ADDR) begin
            irq_mask_q <= pwdata[driver_status_flags_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ==========================================================
    // APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            if (psel && penable && !pready_q) begin
                if (paddr == driver_status_flags_pkg::FLAGS_ADDR) begin
                    prdata_q <= pwrite ? 32'h0000_0000 : status_q;
                end else if (paddr == driver_status_flags_pkg::IRQ_STATUS_ADDR) begin
                    prdata_q <= pwrite ? 32'h0000_0000 : {25'h0, irq_stat_q};
                end else if (paddr == driver_status_flags_pkg::IRQ_MASK_ADDR) begin
                    prdata_q <= pwrite ? 32'h0000_0000 : {25'h0, irq_mask_q};
                end else if (paddr == driver_status_flags_pkg::DRV_CTRL_ADDR) begin
                    prdata_q <= pwrite ? 32'h0000_0000 : {28'h0, off_time_q};
                end else begin
                    pslverr_q <= 1'b1;
                end
            end
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign driver_disable   = drv_off_q;
    assign chopper_off_time = off_time_q;
    assign irq              = irq_q;

    // ==========================================================
    // Checks
    a_gnd_short_hold: assert property (@(posedge pclk) disable iff (!presetn)
        gsb_q && !flag_clear |=> gsb_q ##1 drv_off_q)
        else $error("ground short flag lost or driver left on");
    a_vs_short_set: assert property (@(posedge pclk) disable iff (!presetn)
        vs_det_a |=> vsa_q ##1 drv_off_q)
        else $error("supply short not latched");
    a_vs_sense_sum: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(vsb_q) |-> ({1'b0, $past(bridge_drop_b)} + {1'b0, $past(sense_drop_b)}) > {1'b0, VS_THRESH})
        else $error("supply short without drop sum over threshold");
    a_ovt_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ovt_q && otpw_s |=> ovt_q ##1 drv_off_q)
        else $error("overtemperature released before prewarning");
    a_open_load_info: assert property (@(posedge pclk) disable iff (!presetn)
        !(gsa_q || gsb_q || vsa_q || vsb_q || ovt_q || flag_clear) |=> !drv_off_q)
        else $error("driver disabled without cause");
    a_stall_zero: assert property (@(posedge pclk) disable iff (!presetn)
        load_measurement_value == 10'h000 |=> status_q[driver_status_flags_pkg::STALL_BIT])
        else $error("stall not flagged on zero load");
    a_mode_bits: assert property (@(posedge pclk) disable iff (!presetn)
        quiet_chopper_active && !fullstep_active |=>
        status_q[driver_status_flags_pkg::QUIET_BIT] && !status_q[driver_status_flags_pkg::FS_BIT])
        else $error("chopper mode bits wrong");
    a_cs_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_q[driver_status_flags_pkg::CS_MSB:driver_status_flags_pkg::CS_LSB] == $past(current_scale))
        else $error("current scale not mirrored");
    a_read_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && gsa_q && !flag_clear |=> gsa_q)
        else $error("read altered latched flag");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        |(irq_stat_q & irq_mask_q) |=> irq_q)
        else $error("interrupt not raised");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready_q |=> pready_q)
        else $error("apb answer late");
endmodule // driver_status_regs

/* File: sim/bridge_model.sv */
// Behavioural power bridge and fault detector model
`timescale 1ns/10ps
module bridge_model (
    input  wire logic       driver_disable,
    input  wire logic [5:0] fault_cmd,
    output logic            gnd_short_det_a,
    output logic            gnd_short_det_b,
    output logic            open_load_det_a,
    output logic            open_load_det_b,
    output logic      [7:0] bridge_drop_a,
    output logic      [7:0] bridge_drop_b,
    output logic      [7:0] sense_drop_a,
    output logic      [7:0] sense_drop_b
);
    // ==========================================================
    // Faults: 0 gnd a, 1 gnd b, 2 supply a, 3 supply b, 4 open a, 5 open b
    logic on;
    assign on              = !driver_disable;
    assign gnd_short_det_a = on & fault_cmd[0];
    assign gnd_short_det_b = on & fault_cmd[1];
    assign open_load_det_a = fault_cmd[4];
    assign open_load_det_b = fault_cmd[5];
    // Bridge drop alone stays under threshold, sense drop tips it over
    assign bridge_drop_a   = !on ? 8'h00 : (fault_cmd[2] ? 8'hA0 : 8'h40);
    assign bridge_drop_b   = !on ? 8'h00 : (fault_cmd[3] ? 8'hA0 : 8'h40);
    assign sense_drop_a    = on ? 8'h30 : 8'h00;
    assign sense_drop_b    = on ? 8'h30 : 8'h00;
endmodule // bridge_model

/* File: sim/driver_status_flag_register_test.sv */
// Self-checking bench for the driver status flag register
`timescale 1ns/10ps
module driver_status_flag_register_test;
    // ==========================================================
    // Signals
    localparam logic [31:0] STST = 32'h0000_0040;
    localparam logic [11:0] ST   = driver_status_flags_pkg::FLAGS_ADDR;
    localparam logic [11:0] IRQS = driver_status_flags_pkg::IRQ_STATUS_ADDR;
    localparam logic [11:0] MASK = driver_status_flags_pkg::IRQ_MASK_ADDR;
    localparam logic [11:0] CTRL = driver_status_flags_pkg::DRV_CTRL_ADDR;
    localparam int          FPOS [4] = '{4, 5, 0, 1};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, drv_off, err;
    logic        step_pin, en_n, otpw, ovt, fs, qc, dm, ds, gsa, gsb, ola, olb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [7:0]  bda, bdb, sda, sdb, flg;
    logic [9:0]  ld;
    logic [4:0]  cs;
    logic [3:0]  off_time;
    logic [5:0]  fcmd;
    int          mismatches, n_checks;

    driver_status_regs #(.STST_CYCLES(STST)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_pin(step_pin),
        .driver_enable_pin_n(en_n), .gnd_short_det_a(gsa), .gnd_short_det_b(gsb), .open_load_det_a(ola),
        .open_load_det_b(olb), .otpw_det(otpw), .overtemp_det(ovt), .bridge_drop_a(bda), .bridge_drop_b(bdb),
        .sense_drop_a(sda), .sense_drop_b(sdb), .load_measurement_value(ld), .current_scale(cs),
        .fullstep_active(fs), .quiet_chopper_active(qc), .load_speed_mode(dm), .load_speed_stall(ds),
        .driver_disable(drv_off), .chopper_off_time(off_time), .irq(irq));

    bridge_model bridge (
        .driver_disable(drv_off), .fault_cmd(fcmd), .gnd_short_det_a(gsa), .gnd_short_det_b(gsb),
        .open_load_det_a(ola), .open_load_det_b(olb), .bridge_drop_a(bda), .bridge_drop_b(bdb),
        .sense_drop_a(sda), .sense_drop_b(sdb));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] exp_st(input logic [7:0] f);
        logic [31:0] s;
        s         = 32'h0000_0000;
        s[31]     = 1'b1;
        s[30:25]  = f[7:2];
        s[24]     = (ld == 10'h000) | (dm & ds);
        s[20:16]  = cs;
        s[15]     = fs;
        s[14]     = qc;
        s[13:12]  = f[1:0];
        s[9:0]    = ld;
        return s;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic cyc(input int n); repeat (n) @(posedge pclk); endtask
    task automatic done(input string name); $display("test %s done", name); endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        stop_test();
    end

    // ==========================================================
    // Tests
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        step_pin = 1'b0; en_n = 1'b1; otpw = 1'b0; ovt = 1'b0; fs = 1'b0; qc = 1'b0; dm = 1'b0; ds = 1'b0;
        ld = 10'h155; cs = 5'h00; fcmd = 6'h00; mismatches = 0; n_checks = 0;
        void'($urandom(32'h3074d44c));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check("drv_off", 32'(drv_off), 32'h1);
        check("off time", 32'(off_time), 32'h0);
        check("irq", 32'(irq), 32'h0);
        rd(MASK); check("mask", rdata, 32'h0);
        rd(CTRL); check("ctrl", rdata, 32'h0);
        rd(12'hFF0); check("unmapped err", 32'(err), 32'h1);
        done("reset");
        repeat (10) begin
            step_pin <= 1'b1; cyc(4); step_pin <= 1'b0; cyc(4);
        end
        rd(ST); check("stst moving", 32'(rdata[31]), 32'h0);
        cyc(30);
        rd(ST); check("stst short", 32'(rdata[31]), 32'h0);
        cyc(40);
        rd(ST); check("stst idle", 32'(rdata[31]), 32'h1);
        done("standstill");
        wr(CTRL, 32'h5); en_n <= 1'b0; cyc(4);
        check("off time set", 32'(off_time), 32'h5);
        check("enabled", 32'(drv_off), 32'h0);
        for (int i = 0; i < 24; i++) begin
            ld <= (i % 4 == 0) ? 10'h000 : 10'($urandom());
            cs <= 5'($urandom());
            {fs, qc, dm, ds} <= 4'($urandom());
            rd(ST); check("status live", rdata, exp_st(8'h00));
        end
        wr(ST, 32'hFFFF_FFFF); rd(ST); check("status ro", rdata, exp_st(8'h00));
        done("live fields");
        for (int i = 0; i < 4; i++) begin
            fcmd <= 6'(1 << i); cyc(6); fcmd <= 6'h00; cyc(4);
            check("short off", 32'(drv_off), 32'h1);
            flg = 8'(1 << FPOS[i]);
            rd(ST); check("short flag", rdata, exp_st(flg));
            rd(ST); check("short kept", rdata, exp_st(flg));
            if (i[0]) en_n <= 1'b1; else wr(CTRL, 32'h0);
            cyc(4);
            rd(ST); check("short clear", rdata, exp_st(8'h00));
            en_n <= 1'b0; wr(CTRL, 32'h5); cyc(4);
        end
        done("shorts");
        fcmd <= 6'h30; cyc(6);
        rd(ST); check("open load", rdata, exp_st(8'hC0));
        check("open no trip", 32'(drv_off), 32'h0);
        fcmd <= 6'h00; cyc(4);
        done("open load");
        otpw <= 1'b1; cyc(5);
        rd(ST); check("prewarn", rdata, exp_st(8'h08));
        ovt <= 1'b1; cyc(5);
        rd(ST); check("ovt", rdata, exp_st(8'h0C));
        check("ovt off", 32'(drv_off), 32'h1);
        ovt <= 1'b0; cyc(5);
        check("ovt held", 32'(drv_off), 32'h1);
        otpw <= 1'b0; cyc(6);
        check("ovt cooled", 32'(drv_off), 32'h0);
        rd(ST); check("ovt clear", rdata, exp_st(8'h00));
        done("temperature");
        rd(IRQS); check("irq events", rdata, 32'h7F);
        check("irq masked", 32'(irq), 32'h0);
        wr(MASK, 32'h7F); cyc(2); check("irq on", 32'(irq), 32'h1);
        wr(IRQS, 32'h7F); cyc(2); check("irq cleared", 32'(irq), 32'h0);
        rd(IRQS); check("irq status clr", rdata, 32'h0);
        wr(MASK, 32'h10); otpw <= 1'b1; cyc(6); check("irq prewarn", 32'(irq), 32'h1);
        rd(IRQS); check("irq only prewarn", rdata, 32'h10);
        wr(MASK, 32'h0); cyc(2); check("irq mask off", 32'(irq), 32'h0);
        done("interrupts");
        stop_test();
    end
endmodule // driver_status_flag_register_test
